// ---- include/branch_ops_pkg.sv ----
/*
  Shared constants for the branch and counter-load execute block:
  register byte addresses, the control register field position and encodings.
  Assumes a 32-bit AXI4-Lite bus with word-aligned registers.
*/
package branch_ops_pkg;
  // Register byte addresses
  localparam logic [11:0] ADDR_INSTR   = 12'h000;
  localparam logic [11:0] ADDR_PC      = 12'h004;
  localparam logic [11:0] ADDR_AUX     = 12'h008;
  localparam logic [11:0] ADDR_JR1     = 12'h00C;
  localparam logic [11:0] ADDR_JR2     = 12'h010;
  localparam logic [11:0] ADDR_CTRL    = 12'h014;
  localparam logic [11:0] ADDR_OUTS    = 12'h018;
  localparam logic [11:0] ADDR_TERM    = 12'h020;
  localparam logic [11:0] ADDR_COUNT   = 12'h030;
  localparam logic [11:0] ADDR_ALU     = 12'h040;
  // Status registers keep their printed offsets as word indices
  localparam logic [9:0]  IDX_STAT_A   = 10'h101;
  localparam logic [9:0]  IDX_STAT_B   = 10'h121;
  // Field positions
  localparam int unsigned CTRL_CORE_BIT = 0;
  // Opcode matches
  localparam logic [5:0]  OPC_JSRF     = 6'b00_1111;
  localparam logic [3:0]  OPC_JSRF_LO  = 4'h5;
  localparam logic [4:0]  OPC_JSRR     = 5'b0_0010;
  localparam logic [11:0] OPC_JTSF     = 12'h39B;
  localparam logic [2:0]  OPC_JTSF_LO  = 3'b101;
  localparam logic [10:0] OPC_JTSR     = 11'b001_0111_1001;
  localparam logic [2:0]  OPC_LDCA     = 3'b101;
  localparam logic [2:0]  OPC_LDCA_LO  = 3'b100;
  // Output shortcut actions
  localparam logic [1:0]  ACT_KEEP     = 2'b00;
  localparam logic [1:0]  ACT_OFF      = 2'b01;
  localparam logic [1:0]  ACT_ON       = 2'b10;
  localparam logic [1:0]  ACT_TOGGLE   = 2'b11;
  // Bus responses
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_DECERR  = 2'b11;
  // Reset values
  localparam logic [15:0] RST_WORD     = 16'h0000;
  localparam logic [1:0]  RST_OUTS     = 2'b00;
endpackage

// ---- rtl/branch_ops.sv ----
/*
  Execute logic for conditional/relative jumps, subroutine calls and the
  end-of-count load, with its register file on an AXI4-Lite slave.
  Assumes one clock, synchronous active-low reset and a well-behaved
  master with at most one write and one read outstanding.
*/
`timescale 1ns/1ns

// How it works
// - Taken absolute jump loads jump register address
// - Four-bit field picks status bit by index
// - Polarity zero tests low, one tests high
// - Status bits come from per-core control registers
// - Taken relative jump adds signed five-bit offset
// - Absolute call always jumps to jump register
// - Calls save current program counter in aux
// - Relative call adds signed offset, no condition
// - Operands limited to jump or arithmetic subsets
// - Counter load writes terminal and applies shortcuts
// - Two-bit field picks terminal count a-d
// - Reset flag clears counter or keeps it
// - Shortcut action keep, off, on or toggle
module branch_ops
  import branch_ops_pkg::*;
#(
  parameter int unsigned PC_W = 10  // Program counter width
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [1:0]       shortcut_out
);

  // Refuse widths the offset arithmetic or the 16-bit register merge cannot serve
  if (PC_W < 5 || PC_W > 16) begin : g_chk
    $error("PC_W must lie between 5 and 16");
  end

  logic [11:0]     awaddr_q;           // Held write address
  logic [31:0]     wdata_q;            // Held write data
  logic [3:0]      wstrb_q;            // Held byte enables
  logic            aw_have_q;          // Address captured
  logic            w_have_q;           // Data captured
  logic            wr_do;              // Write commits this cycle
  logic            wr_hit;             // Write address is mapped
  logic [PC_W-1:0] pc_q;               // Program counter
  logic [PC_W-1:0] aux_q;              // Return address
  logic [PC_W-1:0] jr_q [2];           // Jump register subset
  logic [15:0]     alu_q [8];          // Arithmetic register subset
  logic [15:0]     stat_q [2];         // Per-core control and status
  logic            core_sel_q;         // Which core's status is tested
  logic [15:0]     instr_q;            // Last executed instruction
  logic [15:0]     term_q [4];         // Terminal count registers
  logic [15:0]     count_q [4];        // Running counters
  logic [1:0]      out_q;              // Shortcut output states
  logic [15:0]     iw;                 // Instruction being executed
  logic            exec;               // Instruction write strobe
  logic            is_jsrf;
  logic            is_jsrr;
  logic            is_jtsf;
  logic            is_jtsr;
  logic            is_ldca;
  logic            cond;               // Tested bit meets polarity
  logic [PC_W-1:0] rel_pc;             // Relative target
  logic [15:0]     stat_sel;           // Status word under test
  logic [31:0]     rd_mux;             // Read data for araddr
  logic            rd_hit;             // Read address is mapped

  // Byte-lane merge of a write into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] strb);
    logic [15:0] r;
    r = old_v;
    if (strb[0]) r[7:0] = new_v[7:0];
    if (strb[1]) r[15:8] = new_v[15:8];
    return r;
  endfunction

  // Applies one shortcut action to an output state
  function automatic logic apply_act(input logic cur, input logic [1:0] act);
    logic r;
    r = cur;
    case (act)
      ACT_KEEP:   r = cur;
      ACT_OFF:    r = 1'b0;
      ACT_ON:     r = 1'b1;
      ACT_TOGGLE: r = ~cur;
      default:    r = cur;
    endcase
    return r;
  endfunction

  // Write address channel: accept once, hold until response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_have_q     <= 1'b0;
      awaddr_q      <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_have_q     <= 1'b1;
      awaddr_q      <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
      aw_have_q     <= 1'b0;
    end
  end

  // Write data channel, independent of the address order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_have_q     <= 1'b0;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_have_q     <= 1'b1;
      wdata_q      <= s_axi_wdata;
      wstrb_q      <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
      w_have_q     <= 1'b0;
    end
  end

  // Commit once both halves are present and no response is pending
  assign wr_do = aw_have_q && w_have_q && !s_axi_bvalid;

  // Write address decode
  always_comb begin
    wr_hit = 1'b0;
    if (awaddr_q[1:0] == 2'b00) begin
      if (awaddr_q <= ADDR_CTRL || awaddr_q[11:2] == IDX_STAT_A ||
          awaddr_q[11:2] == IDX_STAT_B ||
          (awaddr_q >= ADDR_ALU && awaddr_q < ADDR_ALU + 12'h020))
        wr_hit = (awaddr_q != ADDR_AUX);
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Instruction writes execute in the commit cycle
  assign exec = wr_do && awaddr_q == ADDR_INSTR;
  assign iw   = merge16(instr_q, wdata_q, wstrb_q);

  // Opcode decode; operand fields are too narrow to leave the subsets
  assign is_jsrf = exec && iw[15:10] == OPC_JSRF && iw[3:0] == OPC_JSRF_LO;
  assign is_jsrr = exec && iw[15:11] == OPC_JSRR && !iw[5];
  assign is_jtsf = exec && iw[15:4] == OPC_JTSF && iw[2:0] == OPC_JTSF_LO;
  assign is_jtsr = exec && iw[15:5] == OPC_JTSR;
  assign is_ldca = exec && iw[15:13] == OPC_LDCA && iw[2:0] == OPC_LDCA_LO;

  // Condition test: bit index and polarity sit in different places per opcode
  always_comb begin
    stat_sel = stat_q[core_sel_q];
    if (is_jsrr)
      cond = stat_sel[iw[9:6]] == iw[10];
    else
      cond = stat_sel[iw[8:5]] == iw[9];
  end

  // Offset is sign-extended from bit 4
  assign rel_pc = pc_q + {{(PC_W-5){iw[4]}}, iw[4:0]};

  // Program counter: software load, jumps, or sequential step
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_q <= '0;
    end else if (wr_do && awaddr_q == ADDR_PC) begin
      pc_q <= PC_W'(merge16(16'(pc_q), wdata_q, wstrb_q));
    end else if (is_jsrf && cond) begin
      pc_q <= jr_q[iw[4]];
    end else if (is_jtsf) begin
      pc_q <= jr_q[iw[3]];
    end else if ((is_jsrr && cond) || is_jtsr) begin
      pc_q <= rel_pc;
    end else if (exec) begin
      pc_q <= pc_q + 1'b1;
    end
  end

  // Return address: only the calls touch it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_q <= '0;
    end else if (is_jtsf || is_jtsr) begin
      aux_q <= pc_q;
    end
  end

  // Software-loaded registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      jr_q       <= '{default: '0};
      alu_q      <= '{default: RST_WORD};
      stat_q     <= '{default: RST_WORD};
      core_sel_q <= 1'b0;
      instr_q    <= RST_WORD;
    end else if (wr_do) begin
      if (awaddr_q == ADDR_JR1)
        jr_q[0] <= PC_W'(merge16(16'(jr_q[0]), wdata_q, wstrb_q));
      if (awaddr_q == ADDR_JR2)
        jr_q[1] <= PC_W'(merge16(16'(jr_q[1]), wdata_q, wstrb_q));
      if (awaddr_q == ADDR_CTRL && wstrb_q[0])
        core_sel_q <= wdata_q[CTRL_CORE_BIT];
      if (awaddr_q[11:2] == IDX_STAT_A)
        stat_q[0] <= merge16(stat_q[0], wdata_q, wstrb_q);
      if (awaddr_q[11:2] == IDX_STAT_B)
        stat_q[1] <= merge16(stat_q[1], wdata_q, wstrb_q);
      if (awaddr_q >= ADDR_ALU && awaddr_q < ADDR_ALU + 12'h020 && awaddr_q[1:0] == 2'b00)
        alu_q[awaddr_q[4:2]] <= merge16(alu_q[awaddr_q[4:2]], wdata_q, wstrb_q);
      if (exec)
        instr_q <= iw;
    end
  end

  // Terminal counts follow the counter load
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      term_q <= '{default: RST_WORD};
    end else if (is_ldca) begin
      term_q[iw[7:6]] <= alu_q[iw[5:3]];
    end
  end

  // Counters step each cycle until they meet their terminal count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= '{default: RST_WORD};
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (is_ldca && iw[12] && iw[7:6] == 2'(i))
          count_q[i] <= RST_WORD;
        else if (count_q[i] != term_q[i])
          count_q[i] <= count_q[i] + 16'h0001;
      end
    end
  end

  // Both shortcut actions apply in the same load
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_q <= RST_OUTS;
    end else if (is_ldca) begin
      out_q[0] <= apply_act(out_q[0], iw[11:10]);
      out_q[1] <= apply_act(out_q[1], iw[9:8]);
    end
  end
  assign shortcut_out = out_q;

  // Read decode; unmapped words answer DECERR with zero data
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    if (s_axi_araddr[1:0] != 2'b00)
      rd_hit = 1'b0;
    else if (s_axi_araddr == ADDR_INSTR)
      rd_mux = {16'h0000, instr_q};
    else if (s_axi_araddr == ADDR_PC)
      rd_mux = 32'(pc_q);
    else if (s_axi_araddr == ADDR_AUX)
      rd_mux = 32'(aux_q);
    else if (s_axi_araddr == ADDR_JR1)
      rd_mux = 32'(jr_q[0]);
    else if (s_axi_araddr == ADDR_JR2)
      rd_mux = 32'(jr_q[1]);
    else if (s_axi_araddr == ADDR_CTRL)
      rd_mux = 32'(core_sel_q);
    else if (s_axi_araddr == ADDR_OUTS)
      rd_mux = 32'(out_q);
    else if (s_axi_araddr >= ADDR_TERM && s_axi_araddr < ADDR_COUNT)
      rd_mux = {16'h0000, term_q[s_axi_araddr[3:2]]};
    else if (s_axi_araddr >= ADDR_COUNT && s_axi_araddr < ADDR_ALU)
      rd_mux = {16'h0000, count_q[s_axi_araddr[3:2]]};
    else if (s_axi_araddr >= ADDR_ALU && s_axi_araddr < ADDR_ALU + 12'h020)
      rd_mux = {16'h0000, alu_q[s_axi_araddr[4:2]]};
    else if (s_axi_araddr[11:2] == IDX_STAT_A)
      rd_mux = {16'h0000, stat_q[0]};
    else if (s_axi_araddr[11:2] == IDX_STAT_B)
      rd_mux = {16'h0000, stat_q[1]};
    else
      rd_hit = 1'b0;
  end

  // Read channel: one outstanding read, data registered at acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

endmodule // branch_ops

// ---- sim/branch_ops_properties.sv ----
/*
  Checker for branch_ops: bus answer timing and shortcut output updates.
  Assumes at most one write and one read in flight, full word strobes.
*/
`timescale 1ns/1ns
module branch_ops_properties
  import branch_ops_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  shortcut_out
);
  logic [11:0] wa_q;    // Address of the write in flight
  logic [15:0] wd_q;    // Data word of the write in flight
  logic        ldca_w;  // Write in flight is a counter load

  // Next state of one shortcut output under an action code
  function automatic logic nxt_out(input logic [1:0] act, input logic [1:0] old, input int k);
    case (act)
      ACT_OFF:    return 1'b0;
      ACT_ON:     return 1'b1;
      ACT_TOGGLE: return ~old[k];
      default:    return old[k];
    endcase
  endfunction

  // Keep the payload; slave takes no second write before the answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wa_q <= 12'h000;
      wd_q <= 16'h0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[15:0];
    end
  end

  assign ldca_w = (wa_q == ADDR_INSTR) && (wd_q[15:13] == OPC_LDCA) && (wd_q[2:0] == OPC_LDCA_LO);

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_first_action: assert property (
    $rose(s_axi_bvalid) && ldca_w |-> shortcut_out[0] == nxt_out(wd_q[11:10], $past(shortcut_out), 0))
    else $error("first shortcut output wrong after counter load");
  a_second_action: assert property (
    $rose(s_axi_bvalid) && ldca_w |-> shortcut_out[1] == nxt_out(wd_q[9:8], $past(shortcut_out), 1))
    else $error("second shortcut output wrong after counter load");
  a_outs_hold_other: assert property (
    $rose(s_axi_bvalid) && !ldca_w |-> $stable(shortcut_out))
    else $error("shortcut outputs moved on a write that is no counter load");
  a_outs_change_when: assert property (
    $changed(shortcut_out) && $past(aresetn) |-> $rose(s_axi_bvalid))
    else $error("shortcut outputs moved outside a write commit");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  a_write_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_aux_refused: assert property (
    $rose(s_axi_bvalid) && wa_q == ADDR_AUX |-> s_axi_bresp == RESP_DECERR)
    else $error("write to return register not refused");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  a_read_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed before taken");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
endmodule // branch_ops_properties

bind branch_ops branch_ops_properties chk_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .shortcut_out(shortcut_out));

// ---- sim/microcore_branch_counter_ops_test.sv ----
/*
  Self-checking bench for branch_ops: drives the AXI4-Lite slave only.
  Assumes answers per the hand-over timing; no fixed latency is assumed.
*/
`timescale 1ns/1ns
module microcore_branch_counter_ops_test
  import branch_ops_pkg::*;
;
  localparam logic [15:0] SA = 16'hA5C3;  // Status pattern, core a
  logic        aclk = 1'b0;        // 250 MHz clock
  logic        aresetn = 1'b0;     // Held low at start
  logic [11:0] awaddr = 12'h000;   // Write channel
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  wstrb = 4'hF;       // Byte enables, full word unless a test narrows them
  logic        wvalid = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready = 1'b0;
  logic [11:0] araddr = 12'h000;   // Read channel
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready = 1'b0;
  logic [1:0]  shortcut_out;       // Shortcut states seen
  logic [1:0]  bresp_q;            // Last write response
  logic [1:0]  rresp_q;            // Last read response
  logic [31:0] rdv;                // Last read data
  int          hold_lag = 0;       // Cycles before bready or rready rise, to stall answers
  int          err_total = 0;
  int          num_checks = 0;

  branch_ops uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .shortcut_out(shortcut_out));

  // Clock, half period 2 ns
  always #2 aclk = ~aclk;

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // Address and data offered together, each dropped when taken
  // Waits have no limit of their own: only the watchdog ends a hang
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(aw_done && w_done));
    repeat (hold_lag) @(posedge aclk);
    bready <= 1'b1;
    do begin
      @(posedge aclk);
    end while (!bvalid);
    bresp_q = bresp;
    bready <= 1'b0;
  endtask

  // Address held until taken; data taken at the edge rvalid is seen
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
    end while (!arready);
    arvalid <= 1'b0;
    repeat (hold_lag) @(posedge aclk);
    rready <= 1'b1;
    do begin
      @(posedge aclk);
    end while (!rvalid);
    rdv     = rdata;
    rresp_q = rresp;
    rready  <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(rdv, e);
    chk({30'h0000_0000, rresp_q}, {30'h0000_0000, RESP_OKAY});
  endtask

  // Execute one instruction word
  task automatic ex(input logic [15:0] w);
    wr(ADDR_INSTR, {16'h0000, w});
    chk({30'h0000_0000, bresp_q}, {30'h0000_0000, RESP_OKAY});
  endtask

  function automatic logic nxt(input logic [1:0] act, input logic old);
    return (act == ACT_OFF) ? 1'b0 : (act == ACT_ON) ? 1'b1 : (act == ACT_TOGGLE) ? ~old : old;
  endfunction

  // Reset state, unmapped read, refused write
  task automatic t_regs();
    hold_lag = 4;
    rdc(ADDR_PC, 32'h0000_0000);
    rd(12'h100);
    chk({30'h0000_0000, rresp_q}, {30'h0000_0000, RESP_DECERR});
    wr(ADDR_AUX, 32'h0000_00FF);
    chk({30'h0000_0000, bresp_q}, {30'h0000_0000, RESP_DECERR});
    rdc(ADDR_AUX, 32'h0000_0000);
    // Upper byte lane alone must leave the low byte of the counter intact
    wr(ADDR_PC, 32'h0000_0155);
    wstrb <= 4'h2;
    wr(ADDR_PC, 32'h0000_02AA);
    wstrb <= 4'hF;
    rdc(ADDR_PC, 32'h0000_0255);
    hold_lag = 0;
    $display("t_regs done");
  endtask

  // Every bit, both polarities, both cores; false means next word
  task automatic t_abs_jump();
    logic [15:0] st;
    wr(ADDR_JR1, 32'h0000_0123);
    wr({IDX_STAT_A, 2'b00}, {16'h0000, SA});
    wr({IDX_STAT_B, 2'b00}, {16'h0000, ~SA});
    for (int c = 0; c < 2; c++) begin
      wr(ADDR_CTRL, 32'(c));
      st = c[0] ? ~SA : SA;
      for (int i = 0; i < 32; i++) begin
        wr(ADDR_PC, 32'h0000_0010);
        ex({OPC_JSRF, i[4], i[3:0], 1'b0, OPC_JSRF_LO});
        rdc(ADDR_PC, (st[i[3:0]] == i[4]) ? 32'h0000_0123 : 32'h0000_0011);
      end
    end
    rdc(ADDR_AUX, 32'h0000_0000);
    $display("t_abs_jump done");
  endtask

  // Offset extremes on the top status bit, then a false condition
  task automatic t_rel_jump();
    wr(ADDR_CTRL, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_PC, 32'h0000_0100);
      ex({OPC_JSRR, i < 2, 4'hF, 1'b0, (i == 1) ? 5'h0F : 5'h10});
      rdc(ADDR_PC, (i == 0) ? 32'h0000_00F0 : (i == 1) ? 32'h0000_010F : 32'h0000_0101);
    end
    $display("t_rel_jump done");
  endtask

  // Far call through the second jump register, then a backward call
  task automatic t_calls();
    wr(ADDR_JR2, 32'h0000_02AA);
    wr(ADDR_PC, 32'h0000_0050);
    ex({OPC_JTSF, 1'b1, OPC_JTSF_LO});
    rdc(ADDR_PC, 32'h0000_02AA);
    rdc(ADDR_AUX, 32'h0000_0050);
    ex({OPC_JTSR, 5'h1F});
    rdc(ADDR_PC, 32'h0000_02A9);
    rdc(ADDR_AUX, 32'h0000_02AA);
    $display("t_calls done");
  endtask

  // Each counter, each action code, keep versus clear of the count
  task automatic t_ldca();
    logic [1:0]  eo;
    logic [11:0] ofs;
    eo = 2'b00;
    for (int i = 0; i < 4; i++) begin
      ofs = 12'(4 * i);
      wr(ADDR_ALU + 12'(4 * (7 - i)), 32'h0000_0040 + 32'(i));
      ex({OPC_LDCA, 1'b0, i[1:0], ~i[1:0], i[1:0], 3'(7 - i), OPC_LDCA_LO});
      eo = {nxt(~i[1:0], eo[1]), nxt(i[1:0], eo[0])};
      chk({30'h0000_0000, shortcut_out}, {30'h0000_0000, eo});
      rdc(ADDR_TERM + ofs, 32'h0000_0040 + 32'(i));
      repeat (80) @(posedge aclk);
      ex({OPC_LDCA, 1'b0, 4'h0, i[1:0], 3'(7 - i), OPC_LDCA_LO});
      rdc(ADDR_COUNT + ofs, 32'h0000_0040 + 32'(i));
      ex({OPC_LDCA, 1'b1, 4'h0, i[1:0], 3'h0, OPC_LDCA_LO});
      rdc(ADDR_COUNT + ofs, 32'h0000_0000);
    end
    $display("t_ldca done");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog: tests need well under 10k cycles
  initial begin
    #100000;
    err_total++;
    give_verdict();
  end

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_abs_jump();
    t_rel_jump();
    t_calls();
    t_ldca();
    give_verdict();
  end
endmodule // microcore_branch_counter_ops_test
